// File: rtl/epd_pkg.sv
package epd_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_NUMERATOR = 8'h00;
    localparam logic [7:0] REG_DENOMINATOR = 8'h04;
    localparam logic [7:0] REG_LOGIC_SOURCE = 8'h08;
    localparam logic [7:0] REG_SCALE_Z_INTERVAL = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PENDING = 8'h14;

    localparam int CFG_W = 16;
    localparam int ACC_W = 24;
    localparam int PEND_W = 16;

    // Field positions of the logic/source register
    localparam int SEL_REVERSE_B_BIT = 0;
    localparam int SEL_SOURCE_SCALE_BIT = 1;
    // Field positions of the status register
    localparam int STAT_Z_SEEN_BIT = 0;
    localparam int STAT_ALIGNED_BIT = 1;
    localparam int STAT_RES_LSB = 16;

    localparam logic [CFG_W-1:0] NUMERATOR_RESET = 16'h0001;
    localparam logic [CFG_W-1:0] DENOMINATOR_RESET = 16'h0001;
    localparam logic [1:0] LOGIC_SOURCE_RESET = 2'h0;
    localparam logic [CFG_W-1:0] SCALE_Z_INTERVAL_RESET = 16'h0000;

    // Output edge rate ceiling, counted after quadrupling
    localparam longint CLK_HZ = 100_000_000;
    localparam longint MAX_EDGE_RATE_CPS = 4_000_000;
    localparam int EDGE_GAP_CYCLES = int'((CLK_HZ + MAX_EDGE_RATE_CPS - 1) / MAX_EDGE_RATE_CPS);
    localparam int GAP_W = 5;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [CFG_W-1:0] numerator;
        logic [CFG_W-1:0] denominator;
        logic reverse_b;
        logic source_scale;
        logic [CFG_W-1:0] scale_z_interval;
    } epd_cfg_s;

    typedef struct packed {
        logic a;
        logic b;
    } epd_quad_s;

endpackage

// File: rtl/epd_quad_gen.sv
`timescale 1ns/100ps
module epd_quad_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step_valid,
    input wire logic step_fwd,
    output logic step_ready,
    output logic a_rise,
    output logic a_fall,
    output epd_pkg::epd_quad_s quad
);

    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [epd_pkg::GAP_W-1:0] gap;
    logic [epd_pkg::GAP_W-1:0] next_gap;

    assign step_ready = (gap == '0);

    always_comb begin
        next_phase = phase;
        next_gap = gap;
        if (gap != '0) begin
            next_gap = gap - 1'b1;
        end
        // One edge on A or B per step, direction picks the lead
        if (step_valid && step_ready) begin
            next_phase = step_fwd ? phase + 2'h1 : phase - 2'h1; // [RULE10]
            next_gap = epd_pkg::GAP_W'(epd_pkg::EDGE_GAP_CYCLES - 1); // [RULE5]
        end
    end

    assign a_rise = !phase[1] && next_phase[1];
    assign a_fall = phase[1] && !next_phase[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 2'h0;
            gap <= '0;
        end else begin
            phase <= next_phase;
            gap <= next_gap;
        end
    end

    // Gray sequence 00,01,11,10 on (A,B)
    assign quad.a = phase[1];
    assign quad.b = phase[1] ^ phase[0];

endmodule

// File: rtl/epd_divider.sv
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Function
// (RULE1) Divided encoder or scale position appears as A, B, Z differential outputs.
// (RULE2) Output rate scaled by separate numerator and denominator settings.
// (RULE3) One setting picks A/B logic relation and encoder or scale source.
// (RULE4) Scale source emits Z every programmed scale Z-interval of counts.
// (RULE5) Output edges never exceed 4 million per second after quadrupling.
// (RULE6) Z also driven on a separate single-ended open-collector output.
// (RULE7) Encoder source, resolution multiple of four: Z aligned to A high.
// (RULE8) Encoder source, other resolution: Z one output count wide, unaligned.
// (RULE9) Outputs irregular until first Z; host waits one revolution first.
// (RULE10) A/B stay in quadrature, one edge per count, direction sets lead.
module epd_divider (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic enc_step,
    input wire logic enc_fwd,
    input wire logic enc_index,
    input wire logic scale_step,
    input wire logic scale_fwd,
    output logic phase_a_out_p,
    output logic phase_a_out_n,
    output logic phase_b_out_p,
    output logic phase_b_out_n,
    output logic phase_z_out_p,
    output logic phase_z_out_n,
    output logic phase_z_open_collector_o,
    output logic phase_z_open_collector_oe
);

    // Bus slave
    epd_pkg::epd_cfg_s cfg;
    epd_pkg::epd_cfg_s next_cfg;
    logic dp_write;
    logic next_dp_write;
    logic [7:0] dp_addr;
    logic [7:0] next_dp_addr;
    logic [31:0] next_hrdata;
    logic addr_phase;
    logic [31:0] status_word;
    logic [31:0] pending_word;

    // Division and output state
    logic signed [epd_pkg::ACC_W-1:0] acc;
    logic signed [epd_pkg::ACC_W-1:0] next_acc;
    logic signed [epd_pkg::PEND_W-1:0] pending;
    logic signed [epd_pkg::PEND_W-1:0] next_pending;
    logic z;
    logic next_z;
    logic z_arm;
    logic next_z_arm;
    logic z_seen;
    logic next_z_seen;
    logic [epd_pkg::CFG_W-1:0] res_cnt;
    logic [epd_pkg::CFG_W-1:0] next_res_cnt;
    logic [epd_pkg::CFG_W-1:0] res_last;
    logic [epd_pkg::CFG_W-1:0] next_res_last;
    logic [epd_pkg::CFG_W-1:0] scale_cnt;
    logic [epd_pkg::CFG_W-1:0] next_scale_cnt;

    logic in_step;
    logic in_fwd;
    logic signed [epd_pkg::ACC_W-1:0] num_s;
    logic signed [epd_pkg::ACC_W-1:0] den_s;
    logic step_valid;
    logic step_ready;
    logic step_fire;
    logic a_rise;
    logic a_fall;
    logic aligned_mode;
    epd_pkg::epd_quad_s quad;
    logic next_phase_a_out_p;
    logic next_phase_a_out_n;
    logic next_phase_b_out_p;
    logic next_phase_b_out_n;
    logic next_phase_z_out_p;
    logic next_phase_z_out_n;
    logic next_phase_z_open_collector_oe;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel && hready && (htrans == epd_pkg::HTRANS_NONSEQ || htrans[1]);

    assign status_word = {res_last, 14'h0000, aligned_mode, z_seen};
    assign pending_word = {{(32 - epd_pkg::PEND_W){pending[epd_pkg::PEND_W-1]}}, pending};

    always_comb begin
        next_cfg = cfg;
        next_dp_write = addr_phase && hwrite;
        next_dp_addr = addr_phase ? haddr[7:0] : dp_addr;
        next_hrdata = hrdata;
        if (dp_write) begin
            unique case (dp_addr)
                epd_pkg::REG_NUMERATOR: next_cfg.numerator = hwdata[epd_pkg::CFG_W-1:0]; // [RULE2]
                epd_pkg::REG_DENOMINATOR: next_cfg.denominator = hwdata[epd_pkg::CFG_W-1:0];
                epd_pkg::REG_LOGIC_SOURCE: begin
                    next_cfg.reverse_b = hwdata[epd_pkg::SEL_REVERSE_B_BIT]; // [RULE3]
                    next_cfg.source_scale = hwdata[epd_pkg::SEL_SOURCE_SCALE_BIT];
                end
                epd_pkg::REG_SCALE_Z_INTERVAL: begin
                    next_cfg.scale_z_interval = hwdata[epd_pkg::CFG_W-1:0]; // [RULE4]
                end
                default: begin
                end
            endcase
        end
        if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                epd_pkg::REG_NUMERATOR: next_hrdata = {16'h0000, cfg.numerator};
                epd_pkg::REG_DENOMINATOR: next_hrdata = {16'h0000, cfg.denominator};
                epd_pkg::REG_LOGIC_SOURCE: begin
                    next_hrdata = {30'h00000000, cfg.source_scale, cfg.reverse_b};
                end
                epd_pkg::REG_SCALE_Z_INTERVAL: next_hrdata = {16'h0000, cfg.scale_z_interval};
                epd_pkg::REG_STATUS: next_hrdata = status_word;
                epd_pkg::REG_PENDING: next_hrdata = pending_word;
                default: next_hrdata = 32'h00000000;
            endcase
        end else if (addr_phase) begin
            next_hrdata = 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.numerator <= epd_pkg::NUMERATOR_RESET;
            cfg.denominator <= epd_pkg::DENOMINATOR_RESET;
            cfg.reverse_b <= epd_pkg::LOGIC_SOURCE_RESET[epd_pkg::SEL_REVERSE_B_BIT];
            cfg.source_scale <= epd_pkg::LOGIC_SOURCE_RESET[epd_pkg::SEL_SOURCE_SCALE_BIT];
            cfg.scale_z_interval <= epd_pkg::SCALE_Z_INTERVAL_RESET;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            cfg <= next_cfg;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
        end
    end

    // Source select and fractional division
    assign in_step = cfg.source_scale ? scale_step : enc_step; // [RULE3]
    assign in_fwd = cfg.source_scale ? scale_fwd : enc_fwd;
    assign num_s = $signed({{(epd_pkg::ACC_W - epd_pkg::CFG_W){1'b0}}, cfg.numerator});
    assign den_s = (cfg.denominator == '0) ?
        epd_pkg::ACC_W'(1) :
        $signed({{(epd_pkg::ACC_W - epd_pkg::CFG_W){1'b0}}, cfg.denominator});

    assign step_valid = (pending != '0);
    assign step_fire = step_valid && step_ready;

    always_comb begin
        next_acc = acc;
        next_pending = pending;
        // Each input count adds or subtracts the numerator, each count moved into the backlog removes a denominator
        if (in_step) begin
            next_acc = in_fwd ? acc + num_s : acc - num_s; // [RULE2]
        end
        if (acc >= den_s && pending != {1'b0, {(epd_pkg::PEND_W-1){1'b1}}}) begin
            next_acc = next_acc - den_s;
            next_pending = next_pending + 1'b1;
        end else if (acc <= -den_s && pending != {1'b1, {(epd_pkg::PEND_W-1){1'b0}}}) begin
            next_acc = next_acc + den_s;
            next_pending = next_pending - 1'b1;
        end
        // Backlog drains at the capped edge rate
        if (step_fire) begin
            next_pending = pending[epd_pkg::PEND_W-1] ? next_pending + 1'b1 :
                next_pending - 1'b1; // [RULE5]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= '0;
            pending <= '0;
        end else begin
            acc <= next_acc;
            pending <= next_pending;
        end
    end

    epd_quad_gen u_quad (
        .hclk(hclk),
        .hresetn(hresetn),
        .step_valid(step_valid),
        .step_fwd(!pending[epd_pkg::PEND_W-1]),
        .step_ready(step_ready),
        .a_rise(a_rise),
        .a_fall(a_fall),
        .quad(quad)
    );

    // Z generation
    assign aligned_mode = z_seen && (res_last[1:0] == 2'h0);

    always_comb begin
        next_z = z;
        next_z_arm = z_arm;
        next_z_seen = z_seen;
        next_res_cnt = res_cnt;
        next_res_last = res_last;
        next_scale_cnt = scale_cnt;
        if (step_fire) begin
            next_res_cnt = res_cnt + 1'b1;
        end
        if (cfg.source_scale) begin
            next_z_arm = 1'b0;
            if (step_fire) begin
                next_z = 1'b0;
                if (cfg.scale_z_interval != '0) begin
                    if (scale_cnt >= cfg.scale_z_interval - 1'b1) begin
                        next_scale_cnt = '0;
                        next_z = 1'b1; // [RULE4]
                    end else begin
                        next_scale_cnt = scale_cnt + 1'b1;
                    end
                end
            end
        end else begin
            next_scale_cnt = '0;
            if (aligned_mode) begin
                if (z_arm && a_rise) begin
                    next_z = 1'b1; // [RULE7]
                    next_z_arm = 1'b0;
                end else if (z && a_fall) begin
                    next_z = 1'b0; // [RULE7]
                end
            end else if (step_fire) begin
                if (z_arm) begin
                    next_z = 1'b1; // [RULE8]
                    next_z_arm = 1'b0;
                end else begin
                    next_z = 1'b0; // [RULE8]
                end
            end
            // Index sets win over the clears above
            if (enc_index) begin
                next_z_arm = 1'b1;
                next_z_seen = 1'b1; // [RULE9]
                next_res_last = res_cnt;
                next_res_cnt = step_fire ? epd_pkg::CFG_W'(1) : '0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            z <= 1'b0;
            z_arm <= 1'b0;
            z_seen <= 1'b0;
            res_cnt <= '0;
            res_last <= '0;
            scale_cnt <= '0;
        end else begin
            z <= next_z;
            z_arm <= next_z_arm;
            z_seen <= next_z_seen;
            res_cnt <= next_res_cnt;
            res_last <= next_res_last;
            scale_cnt <= next_scale_cnt;
        end
    end

    // Pins registered so both wires of a pair switch on the same edge
    always_comb begin
        next_phase_a_out_p = quad.a; // [RULE1]
        next_phase_a_out_n = !quad.a;
        next_phase_b_out_p = quad.b ^ cfg.reverse_b; // [RULE3]
        next_phase_b_out_n = !(quad.b ^ cfg.reverse_b);
        next_phase_z_out_p = z; // [RULE1]
        next_phase_z_out_n = !z;
        next_phase_z_open_collector_oe = z; // [RULE6]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_a_out_p <= 1'b0;
            phase_a_out_n <= 1'b1;
            phase_b_out_p <= epd_pkg::LOGIC_SOURCE_RESET[epd_pkg::SEL_REVERSE_B_BIT];
            phase_b_out_n <= !epd_pkg::LOGIC_SOURCE_RESET[epd_pkg::SEL_REVERSE_B_BIT];
            phase_z_out_p <= 1'b0;
            phase_z_out_n <= 1'b1;
            phase_z_open_collector_oe <= 1'b0;
        end else begin
            phase_a_out_p <= next_phase_a_out_p;
            phase_a_out_n <= next_phase_a_out_n;
            phase_b_out_p <= next_phase_b_out_p;
            phase_b_out_n <= next_phase_b_out_n;
            phase_z_out_p <= next_phase_z_out_p;
            phase_z_out_n <= next_phase_z_out_n;
            phase_z_open_collector_oe <= next_phase_z_open_collector_oe;
        end
    end

    assign phase_z_open_collector_o = 1'b0;

endmodule

// File: test/epd_divider_props.sv
`timescale 1ns/100ps
module epd_divider_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic phase_a_out_p,
    input wire logic phase_a_out_n,
    input wire logic phase_b_out_p,
    input wire logic phase_b_out_n,
    input wire logic phase_z_out_p,
    input wire logic phase_z_out_n,
    input wire logic phase_z_open_collector_o,
    input wire logic phase_z_open_collector_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [4:0] gap, next_gap;
    logic [1:0] ab_q;
    // Cycles since the last A/B edge, saturating
    always_comb begin
        next_gap = (gap == 5'h1f) ? gap : gap + 5'h1;
        if ({phase_a_out_p, phase_b_out_p} != ab_q)
            next_gap = 5'h0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap <= 5'h1f;
            ab_q <= 2'h0;
        end else begin
            gap <= next_gap;
            ab_q <= {phase_a_out_p, phase_b_out_p};
        end
    end
    a_a_pair_inv: assert property (phase_a_out_n == !phase_a_out_p)
        else $error("A pair not complementary");
    a_b_pair_inv: assert property (phase_b_out_n == !phase_b_out_p)
        else $error("B pair not complementary");
    a_z_pair_inv: assert property (phase_z_out_n == !phase_z_out_p)
        else $error("Z pair not complementary");
    a_oc_tracks_z: assert property (phase_z_open_collector_oe == phase_z_out_p
        && !phase_z_open_collector_o)
        else $error("open collector Z differs from Z");
    a_single_phase: assert property (!($changed(phase_a_out_p)
        && $changed(phase_b_out_p)))
        else $error("A and B changed together");
    a_edge_gap: assert property ({phase_a_out_p, phase_b_out_p} != ab_q
        |-> gap >= 5'h18)
        else $error("output edges closer than 25 cycles");
    a_z_rise_edge: assert property ($rose(phase_z_out_p)
        |-> {phase_a_out_p, phase_b_out_p} != ab_q)
        else $error("Z rose without an output edge");
    a_z_fall_edge: assert property ($fell(phase_z_out_p)
        |-> {phase_a_out_p, phase_b_out_p} != ab_q)
        else $error("Z fell without an output edge");
endmodule
bind epd_divider epd_divider_props u_props (.hclk, .hresetn, .phase_a_out_p, .phase_a_out_n,
    .phase_b_out_p, .phase_b_out_n, .phase_z_out_p, .phase_z_out_n,
    .phase_z_open_collector_o, .phase_z_open_collector_oe);

// File: test/epd_host_counter.sv
`timescale 1ns/100ps
module epd_host_counter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic a,
    input wire logic b,
    input wire logic z,
    output logic signed [31:0] pos,
    output logic [15:0] z_count,
    output logic z_seen
);
    logic [1:0] ab_q;
    logic z_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ab_q <= 2'h0;
            z_q <= 1'b0;
            pos <= 32'sh0;
            z_count <= 16'h0;
            z_seen <= 1'b0;
        end else begin
            ab_q <= {a, b};
            z_q <= z;
            // Quadrature decode, B leading A counts up
            if ({ab_q, a, b} inside {4'h1, 4'h7, 4'he, 4'h8})
                pos <= pos + 32'sh1;
            else if ({ab_q, a, b} inside {4'h4, 4'hd, 4'hb, 4'h2})
                pos <= pos - 32'sh1;
            // Feedback trusted only once a Z pulse has been seen
            if (z && !z_q) begin
                z_count <= z_count + 16'h1;
                z_seen <= 1'b1;
            end
        end
    end
endmodule

// File: test/epd_divider_bench.sv
`timescale 1ns/100ps
module epd_divider_bench;
    logic hclk, hresetn, hsel, hwrite, rd_dp;
    logic enc_step, enc_fwd, enc_index, scale_step, scale_fwd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, lfsr, chk_val, pos;
    logic hreadyout, hresp, a_p, a_n, b_p, b_n, z_p, z_n, oc_o, oc_oe, hzs;
    logic signed [31:0] hpos;
    logic [15:0] hz;
    logic [31:0] exp_q[$];
    logic [31:0] nu[4] = '{32'h1, 32'h1, 32'h3, 32'h2};
    logic [31:0] de[4] = '{32'h1, 32'h2, 32'h1, 32'h3};
    logic [31:0] cn[4] = '{32'ha, 32'ha, 32'h4, 32'h6};
    logic [31:0] dl[4] = '{32'ha, -32'h5, 32'hc, 32'h4};
    logic fw[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    int gp[4] = '{0, 30, 80, 30};
    int failures, check_count;
    event chk_ev;
    // Open-collector pin with pull-up
    wire logic oc_pin = oc_oe ? oc_o : 1'b1;
    epd_divider DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .enc_step, .enc_fwd, .enc_index,
        .scale_step, .scale_fwd, .phase_a_out_p(a_p), .phase_a_out_n(a_n),
        .phase_b_out_p(b_p), .phase_b_out_n(b_n), .phase_z_out_p(z_p),
        .phase_z_out_n(z_n), .phase_z_open_collector_o(oc_o),
        .phase_z_open_collector_oe(oc_oe));
    epd_host_counter hst (.hclk, .hresetn, .a(a_p), .b(b_p), .z(!oc_pin), .pos(hpos),
        .z_count(hz), .z_seen(hzs));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (e !== g) begin
            failures++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    always @(posedge hclk) if (rd_dp && hreadyout) cmp(exp_q.pop_front(), hrdata);
    always @(posedge hclk) if (rd_dp && hreadyout) cmp(32'h0, {31'h0, hresp});
    always @(chk_ev) cmp(exp_q.pop_front(), chk_val);
    task automatic note(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        chk_val = g;
        ->chk_ev;
        #1;
    endtask
    // Single AHB transfer; on a read d is the expected data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= epd_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rd_dp <= !wr;
        if (!wr) exp_q.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    task automatic steps(input logic [31:0] n, input logic fwd, input logic scl, input int gap);
        repeat (30) @(posedge hclk);
        repeat (n) begin
            @(posedge hclk);
            enc_fwd <= fwd;
            scale_fwd <= fwd;
            enc_step <= !scl;
            scale_step <= scl;
            @(posedge hclk);
            enc_step <= 1'b0;
            scale_step <= 1'b0;
            repeat (gap) @(posedge hclk);
        end
        repeat (400) @(posedge hclk);
    endtask
    task automatic index_pulse;
        @(posedge hclk);
        enc_index <= 1'b1;
        @(posedge hclk);
        enc_index <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        {hsel, hwrite, rd_dp, enc_step, enc_fwd, enc_index, scale_step, scale_fwd} = 8'h0;
        {hresetn, htrans, hsize, haddr, hwdata, pos} = {1'b0, 2'h0, 3'h2, 96'h0};
        failures = 0;
        check_count = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, epd_pkg::REG_NUMERATOR, 32'h1);
        bus(1'b0, epd_pkg::REG_DENOMINATOR, 32'h1);
        bus(1'b0, epd_pkg::REG_LOGIC_SOURCE, 32'h0);
        bus(1'b0, epd_pkg::REG_SCALE_Z_INTERVAL, 32'h0);
        bus(1'b1, 8'h20, 32'hffff);
        bus(1'b0, 8'h20, 32'h0);
        lfsr = 32'h801f;
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            bus(1'b1, epd_pkg::REG_NUMERATOR, lfsr);
            bus(1'b0, epd_pkg::REG_NUMERATOR, {16'h0, lfsr[15:0]});
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, epd_pkg::REG_NUMERATOR, nu[i]);
            bus(1'b1, epd_pkg::REG_DENOMINATOR, de[i]);
            steps(cn[i], fw[i], 1'b0, gp[i]);
            pos = pos + dl[i];
            note(pos, hpos);
        end
        bus(1'b0, epd_pkg::REG_PENDING, 32'h0);
        bus(1'b1, epd_pkg::REG_NUMERATOR, 32'h1);
        bus(1'b1, epd_pkg::REG_DENOMINATOR, 32'h1);
        bus(1'b1, epd_pkg::REG_LOGIC_SOURCE, 32'h1);
        steps(32'h6, 1'b1, 1'b0, 30);
        bus(1'b1, epd_pkg::REG_LOGIC_SOURCE, 32'h0);
        pos = pos - 32'h6;
        // Let the B flip from the logic write reach the host count
        repeat (4) @(posedge hclk);
        note(pos, hpos);
        index_pulse;
        steps(32'h8, 1'b1, 1'b0, 30);
        index_pulse;
        bus(1'b0, epd_pkg::REG_STATUS, 32'h0008_0003);
        steps(32'h6, 1'b1, 1'b0, 30);
        index_pulse;
        bus(1'b0, epd_pkg::REG_STATUS, 32'h0006_0001);
        steps(32'h8, 1'b1, 1'b0, 30);
        pos = pos + 32'h16;
        note(pos, hpos);
        note(32'h3, {16'h0, hz});
        note(32'h1, {31'h0, hzs});
        bus(1'b1, epd_pkg::REG_SCALE_Z_INTERVAL, 32'h4);
        bus(1'b1, epd_pkg::REG_LOGIC_SOURCE, 32'h2);
        steps(32'h8, 1'b1, 1'b1, 30);
        steps(32'h4, 1'b1, 1'b0, 30);
        pos = pos + 32'h8;
        note(pos, hpos);
        note(32'h5, {16'h0, hz});
        tally_and_finish();
    end
    initial begin
        #300_000;
        failures++;
        tally_and_finish();
    end
endmodule
